// ===== core/pbd_cfg.svh
/*
 * bit positions, pin indices and reset values for the port b/d
 * alternate-function override logic.
 * assumes nothing; definitions only.
 */
`ifndef PBD_CFG_SVH
`define PBD_CFG_SVH

// =============================================
// port widths
`define PBD_PB_WIDTH 8
`define PBD_PD_WIDTH 7

// =============================================
// port b pin indices
`define PBD_PB_CMP0A 2
`define PBD_PB_CMP1A 3
`define PBD_PB_CMP1B 4
`define PBD_PB_SDA 5
`define PBD_PB_DOUT 6
`define PBD_PB_SCK 7

// =============================================
// port d pin indices
`define PBD_PD_RXD 0
`define PBD_PD_TXD 1
`define PBD_PD_EXT_IRQ_ZERO 2
`define PBD_PD_EXT_IRQ_ONE 3
`define PBD_PD_T0 4
`define PBD_PD_T1 5
`define PBD_PD_ICP 6

// =============================================
// pin change source numbering
`define PBD_PCG0_LO 0
`define PBD_PCG0_HI 7
`define PBD_PCG2_LO 11
`define PBD_PCG2_HI 17

// =============================================
// reset values
`define PBD_RST_BIT 1'h0
`define PBD_RST_OE_N 1'h1

`endif

// ===== core/pbd_pkg.sv
/*
 * types shared by the port b/d override logic.
 * assumes pbd_cfg.svh is not needed here.
 */
package pbd_pkg;

    // override enables and values for one pin
    typedef struct packed {
        logic pu_oe;
        logic pu_ov;
        logic dd_oe;
        logic dd_ov;
        logic pv_oe;
        logic pv_ov;
        logic die_oe;
        logic die_ov;
    } pbd_ovr_t;

    // resolved pad controls for one pin
    typedef struct packed {
        logic out;
        logic oe_n;
        logic pull;
        logic die;
    } pbd_pad_t;

endpackage

// ===== core/pbd_pin_res.sv
/*
 * one pin: merges port register bits with alternate-function overrides
 * into registered pad controls.
 * assumes synchronous inputs on sys_clk and synchronous active-low reset.
 */
`timescale 1ns/10ps
`include "pbd_cfg.svh"

module pbd_pin_res
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input pbd_pkg::pbd_ovr_t ovr,
    input wire logic port_val,
    input wire logic port_dir,
    input wire logic pull_up_disable,
    input wire logic sleep_active,
    output pbd_pkg::pbd_pad_t pad
);
    import pbd_pkg::*;

    // =============================================
    // override selection
    wire logic dir_eff = ovr.dd_oe ? ovr.dd_ov : port_dir;
    wire logic val_eff = ovr.pv_oe ? ovr.pv_ov : port_val;
    wire logic pull_norm = ~port_dir & port_val & ~pull_up_disable;
    wire logic pull_eff = ovr.pu_oe ? ovr.pu_ov : pull_norm;
    wire logic die_eff = ovr.die_oe ? ovr.die_ov : ~sleep_active;
    pbd_pad_t pad_d;

    assign pad_d = '{out: val_eff, oe_n: ~dir_eff, pull: pull_eff, die: die_eff};

    // =============================================
    // pad register
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pad <= '{out: `PBD_RST_BIT, oe_n: `PBD_RST_OE_N, pull: `PBD_RST_BIT, die: `PBD_RST_BIT};
        else
            pad <= pad_d;
    end

    // =============================================
    // checks
    property p_ovr_wins;
        @(posedge sys_clk) disable iff (!rst_n)
        (ovr.pu_oe && ovr.dd_oe) |=> (pad.pull == $past(ovr.pu_ov)) && (pad.oe_n == !$past(ovr.dd_ov));
    endproperty
    a_ovr_wins: assert property (p_ovr_wins) else $error("override value not applied");

endmodule

// ===== core/pbd_altfn_mux.sv
/*
 * alternate-function override mux for port b and port d pins.
 * assumes all inputs synchronous to sys_clk (50 mhz), reset synchronous
 * active low, peripherals and port registers outside this block.
 */
`timescale 1ns/10ps
`include "pbd_cfg.svh"


module pbd_altfn_mux
#(
    parameter int PB_W = `PBD_PB_WIDTH,
    parameter int PD_W = `PBD_PD_WIDTH
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [PB_W-1:0] portb_value,
    input wire logic [PB_W-1:0] portb_dir,
    input wire logic [PD_W-1:0] portd_value,
    input wire logic [PD_W-1:0] portd_dir,
    input wire logic [PB_W-1:0] pin_in_b,
    input wire logic [PD_W-1:0] pin_in_d,
    input wire logic pull_up_disable,
    input wire logic sleep_active,
    input wire logic two_wire_mode_active,
    input wire logic three_wire_mode_active,
    input wire logic clock_line_hold,
    input wire logic serial_pin_toggle_enable,
    input wire logic serial_clk_toggle,
    input wire logic start_cond_irq_enable,
    input wire logic serial_data_out,
    input wire logic serial_sda_bit,
    input wire logic timer0_cmp_a_en,
    input wire logic timer0_cmp_a_out,
    input wire logic timer1_cmp_a_en,
    input wire logic timer1_cmp_a_out,
    input wire logic timer1_cmp_b_en,
    input wire logic timer1_cmp_b_out,
    input wire logic timer0_cmp_b_en,
    input wire logic timer0_cmp_b_out,
    input wire logic pinchg_grp0_enable,
    input wire logic pinchg_grp2_enable,
    input wire logic [PB_W-1:0] pinchg_mask_b,
    input wire logic [PD_W-1:0] pinchg_mask_d,
    input wire logic uart_rx_enable,
    input wire logic uart_tx_enable,
    input wire logic uart_tx_data,
    input wire logic usart_sync_mode,
    input wire logic usart_clk_out_en,
    input wire logic usart_clk_out,
    input wire logic sysclk_output_en,
    input wire logic sysclk_output_level,
    input wire logic ext_irq_zero_en,
    input wire logic ext_irq_one_en,
    input wire logic timer0_ext_clock_en,
    input wire logic timer1_ext_clock_en,
    input wire logic timer1_capture_en,
    output pbd_pkg::pbd_pad_t [PB_W-1:0] pad_b,
    output pbd_pkg::pbd_pad_t [PD_W-1:0] pad_d,
    output logic [`PBD_PCG0_HI:`PBD_PCG0_LO] pinchg_grp0_src,
    output logic [`PBD_PCG2_HI:`PBD_PCG2_LO] pinchg_grp2_src,
    output logic serial_data_in,
    output logic serial_unit_clock,
    output logic uart_rx_in,
    output logic ext_irq_zero,
    output logic ext_irq_one,
    output logic usart_sync_clock,
    output logic timer0_ext_clock,
    output logic timer1_ext_clock,
    output logic timer1_capture_in
);
    import pbd_pkg::*;

    // =============================================
    // serial clock toggle state
    logic sck_tog_q;
    wire logic sck_tog_d = serial_pin_toggle_enable & (sck_tog_q ^ serial_clk_toggle);
    wire logic pb7_val = portb_value[`PBD_PB_SCK] ^ sck_tog_q;
    wire logic [PB_W-1:0] portb_eff = {pb7_val, portb_value[PB_W-2:0]};

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sck_tog_q <= `PBD_RST_BIT;
        else
            sck_tog_q <= sck_tog_d;
    end

    // =============================================
    // override terms
    wire logic [PB_W-1:0] pcb_on = pinchg_mask_b & {PB_W{pinchg_grp0_enable}};
    wire logic [PD_W-1:0] pcd_on = pinchg_mask_d & {PD_W{pinchg_grp2_enable}};
    wire logic tw = two_wire_mode_active;
    wire logic scl_dir = (clock_line_hold | pb7_val) & portb_dir[`PBD_PB_SCK];
    wire logic sda_dir = (serial_sda_bit | portb_value[`PBD_PB_SDA]) & portb_dir[`PBD_PB_SDA];
    wire logic pd2_pv_oe = sysclk_output_en | usart_clk_out_en;
    wire logic pd2_pv_ov = sysclk_output_en ? sysclk_output_level : usart_clk_out;
    wire logic pd0_pu = portd_value[`PBD_PD_RXD] & ~pull_up_disable;
    pbd_ovr_t ovr_b [PB_W];
    pbd_ovr_t ovr_d [PD_W];

    always_comb
    begin
        for (int i = 0; i < PB_W; i++)
            ovr_b[i] = '{pu_oe: 1'h0, pu_ov: 1'h0, dd_oe: 1'h0, dd_ov: 1'h0, pv_oe: 1'h0, pv_ov: 1'h0,
                         die_oe: pcb_on[i], die_ov: 1'h1};
        for (int i = 0; i < PD_W; i++)
            ovr_d[i] = '{pu_oe: 1'h0, pu_ov: 1'h0, dd_oe: 1'h0, dd_ov: 1'h0, pv_oe: 1'h0, pv_ov: 1'h0,
                         die_oe: pcd_on[i], die_ov: 1'h1};
        // compare outputs on port b
        ovr_b[`PBD_PB_CMP0A].pv_oe = timer0_cmp_a_en;
        ovr_b[`PBD_PB_CMP0A].pv_ov = timer0_cmp_a_out;
        ovr_b[`PBD_PB_CMP1A].pv_oe = timer1_cmp_a_en;
        ovr_b[`PBD_PB_CMP1A].pv_ov = timer1_cmp_a_out;
        ovr_b[`PBD_PB_CMP1B].pv_oe = timer1_cmp_b_en;
        ovr_b[`PBD_PB_CMP1B].pv_ov = timer1_cmp_b_out;
        // two-wire data / three-wire data input
        ovr_b[`PBD_PB_SDA].dd_oe = tw;
        ovr_b[`PBD_PB_SDA].dd_ov = sda_dir;
        ovr_b[`PBD_PB_SDA].pv_oe = tw & portb_dir[`PBD_PB_SDA];
        ovr_b[`PBD_PB_SDA].die_oe = pcb_on[`PBD_PB_SDA] | start_cond_irq_enable;
        // three-wire data output, pull-up left to the port bit
        ovr_b[`PBD_PB_DOUT].pv_oe = three_wire_mode_active;
        ovr_b[`PBD_PB_DOUT].pv_ov = serial_data_out;
        // serial clock
        ovr_b[`PBD_PB_SCK].pu_oe = tw;
        ovr_b[`PBD_PB_SCK].dd_oe = tw;
        ovr_b[`PBD_PB_SCK].dd_ov = scl_dir;
        ovr_b[`PBD_PB_SCK].pv_oe = tw & portb_dir[`PBD_PB_SCK];
        ovr_b[`PBD_PB_SCK].die_oe = pcb_on[`PBD_PB_SCK] | start_cond_irq_enable;
        // uart receive
        ovr_d[`PBD_PD_RXD].pu_oe = uart_rx_enable;
        ovr_d[`PBD_PD_RXD].pu_ov = pd0_pu;
        ovr_d[`PBD_PD_RXD].dd_oe = uart_rx_enable;
        // uart transmit
        ovr_d[`PBD_PD_TXD].pu_oe = uart_tx_enable;
        ovr_d[`PBD_PD_TXD].dd_oe = uart_tx_enable;
        ovr_d[`PBD_PD_TXD].dd_ov = 1'h1;
        ovr_d[`PBD_PD_TXD].pv_oe = uart_tx_enable;
        ovr_d[`PBD_PD_TXD].pv_ov = uart_tx_data;
        // pd2 clock outputs and interrupt input; pd3 interrupt and pd4 timer clock inputs
        ovr_d[`PBD_PD_EXT_IRQ_ZERO].pv_oe = pd2_pv_oe;
        ovr_d[`PBD_PD_EXT_IRQ_ZERO].pv_ov = pd2_pv_ov;
        ovr_d[`PBD_PD_EXT_IRQ_ZERO].die_oe = pcd_on[`PBD_PD_EXT_IRQ_ZERO] | ext_irq_zero_en | usart_sync_mode;
        ovr_d[`PBD_PD_EXT_IRQ_ONE].die_oe = pcd_on[`PBD_PD_EXT_IRQ_ONE] | ext_irq_one_en;
        ovr_d[`PBD_PD_T0].die_oe = pcd_on[`PBD_PD_T0] | timer0_ext_clock_en;
        // pd5 compare output needs its direction bit from software
        ovr_d[`PBD_PD_T1].pv_oe = timer0_cmp_b_en;
        ovr_d[`PBD_PD_T1].pv_ov = timer0_cmp_b_out;
        ovr_d[`PBD_PD_T1].die_oe = pcd_on[`PBD_PD_T1] | timer1_ext_clock_en;
        ovr_d[`PBD_PD_ICP].die_oe = pcd_on[`PBD_PD_ICP] | timer1_capture_en;
    end

    // =============================================
    // per-pin resolvers
    for (genvar g = 0; g < PB_W; g++)
    begin : g_pb
        pbd_pin_res u_res
        (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ovr(ovr_b[g]),
            .port_val(portb_eff[g]),
            .port_dir(portb_dir[g]),
            .pull_up_disable(pull_up_disable),
            .sleep_active(sleep_active),
            .pad(pad_b[g])
        );
    end

    for (genvar g = 0; g < PD_W; g++)
    begin : g_pd
        pbd_pin_res u_res
        (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ovr(ovr_d[g]),
            .port_val(portd_value[g]),
            .port_dir(portd_dir[g]),
            .pull_up_disable(pull_up_disable),
            .sleep_active(sleep_active),
            .pad(pad_d[g])
        );
    end

    // =============================================
    // gated inputs to peripherals
    logic [PB_W-1:0] die_b;
    logic [PD_W-1:0] die_d;
    always_comb
    begin
        for (int i = 0; i < PB_W; i++)
            die_b[i] = pad_b[i].die;
        for (int i = 0; i < PD_W; i++)
            die_d[i] = pad_d[i].die;
    end
    wire logic [PB_W-1:0] in_b = pin_in_b & die_b;
    wire logic [PD_W-1:0] in_d = pin_in_d & die_d;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pinchg_grp0_src <= '0;
            pinchg_grp2_src <= '0;
            serial_data_in <= `PBD_RST_BIT;
            serial_unit_clock <= `PBD_RST_BIT;
            uart_rx_in <= `PBD_RST_BIT;
            ext_irq_zero <= `PBD_RST_BIT;
            ext_irq_one <= `PBD_RST_BIT;
            usart_sync_clock <= `PBD_RST_BIT;
            timer0_ext_clock <= `PBD_RST_BIT;
            timer1_ext_clock <= `PBD_RST_BIT;
            timer1_capture_in <= `PBD_RST_BIT;
        end
        else
        begin
            pinchg_grp0_src <= in_b;
            pinchg_grp2_src <= in_d;
            serial_data_in <= in_b[`PBD_PB_SDA];
            serial_unit_clock <= in_b[`PBD_PB_SCK];
            uart_rx_in <= in_d[`PBD_PD_RXD];
            ext_irq_zero <= in_d[`PBD_PD_EXT_IRQ_ZERO];
            ext_irq_one <= in_d[`PBD_PD_EXT_IRQ_ONE];
            usart_sync_clock <= in_d[`PBD_PD_EXT_IRQ_ZERO] & usart_sync_mode;
            timer0_ext_clock <= in_d[`PBD_PD_T0];
            timer1_ext_clock <= in_d[`PBD_PD_T1];
            timer1_capture_in <= in_d[`PBD_PD_ICP];
        end
    end

    // =============================================
    // checks
    property p_di_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        !tw |=> pad_b[`PBD_PB_SDA].oe_n == !$past(portb_dir[`PBD_PB_SDA]);
    endproperty
    a_di_dir: assert property (p_di_dir) else $error("data input direction overridden");

    property p_do_val;
        @(posedge sys_clk) disable iff (!rst_n)
        (three_wire_mode_active && portb_dir[`PBD_PB_DOUT])
        |=> (pad_b[`PBD_PB_DOUT].out == $past(serial_data_out)) && !pad_b[`PBD_PB_DOUT].oe_n;
    endproperty
    a_do_val: assert property (p_do_val) else $error("data out not on pin 6");

    property p_do_pull;
        @(posedge sys_clk) disable iff (!rst_n)
        (three_wire_mode_active && !portb_dir[`PBD_PB_DOUT] && portb_value[`PBD_PB_DOUT] && !pull_up_disable)
        |=> pad_b[`PBD_PB_DOUT].pull;
    endproperty
    a_do_pull: assert property (p_do_pull) else $error("pin 6 pull-up lost");

    property p_scl;
        @(posedge sys_clk) disable iff (!rst_n)
        (tw && clock_line_hold && portb_dir[`PBD_PB_SCK])
        |=> !pad_b[`PBD_PB_SCK].pull && !pad_b[`PBD_PB_SCK].oe_n && !pad_b[`PBD_PB_SCK].out;
    endproperty
    a_scl: assert property (p_scl) else $error("clock pin not held low");

    property p_sda;
        @(posedge sys_clk) disable iff (!rst_n)
        (tw && !serial_sda_bit && !portb_value[`PBD_PB_SDA]) |=> pad_b[`PBD_PB_SDA].oe_n;
    endproperty
    a_sda: assert property (p_sda) else $error("data pin driven while released");

    property p_cmp0a;
        @(posedge sys_clk) disable iff (!rst_n)
        timer0_cmp_a_en |=> pad_b[`PBD_PB_CMP0A].out == $past(timer0_cmp_a_out);
    endproperty
    a_cmp0a: assert property (p_cmp0a) else $error("compare value not on pin 2");

    property p_start_die;
        @(posedge sys_clk) disable iff (!rst_n)
        start_cond_irq_enable |=> pad_b[`PBD_PB_SCK].die && pad_b[`PBD_PB_SDA].die;
    endproperty
    a_start_die: assert property (p_start_die) else $error("serial inputs disabled");

    property p_pcg0;
        @(posedge sys_clk) disable iff (!rst_n)
        (pinchg_grp0_enable && pinchg_mask_b[`PBD_PB_DOUT])[*2]
        |=> pinchg_grp0_src[`PBD_PB_DOUT] == $past(pin_in_b[`PBD_PB_DOUT]);
    endproperty
    a_pcg0: assert property (p_pcg0) else $error("source 6 not following pin");

    property p_txd;
        @(posedge sys_clk) disable iff (!rst_n)
        uart_tx_enable |=> (pad_d[`PBD_PD_TXD].out == $past(uart_tx_data)) && !pad_d[`PBD_PD_TXD].oe_n;
    endproperty
    a_txd: assert property (p_txd) else $error("transmit data not on pd1");

    property p_xck;
        @(posedge sys_clk) disable iff (!rst_n)
        !usart_sync_mode |=> !usart_sync_clock;
    endproperty
    a_xck: assert property (p_xck) else $error("usart clock outside sync mode");

    property p_sysclk_output;
        @(posedge sys_clk) disable iff (!rst_n)
        sysclk_output_en |=> pad_d[`PBD_PD_EXT_IRQ_ZERO].out == $past(sysclk_output_level);
    endproperty
    a_sysclk_output: assert property (p_sysclk_output) else $error("clock output missing on pd2");

endmodule

// ===== verification/pbd_pin_model.sv
/*
 * pin-side partner of the port b/d override mux: resolves each pad level
 * from the mux drive, an external driver and the pull-up.
 * assumes pad controls registered on sys_clk; oe_n low means the mux drives.
 */
`timescale 1ns/10ps

module pbd_pin_model
#(
    parameter int PB_W = 8,
    parameter int PD_W = 7
)
(
    input wire logic sys_clk,
    input pbd_pkg::pbd_pad_t [PB_W-1:0] pad_b,
    input pbd_pkg::pbd_pad_t [PD_W-1:0] pad_d,
    input wire logic [PB_W-1:0] ext_b,
    input wire logic [PB_W-1:0] ext_en_b,
    input wire logic [PD_W-1:0] ext_d,
    input wire logic [PD_W-1:0] ext_en_d,
    output logic [PB_W-1:0] pin_in_b,
    output logic [PD_W-1:0] pin_in_d
);
    import pbd_pkg::*;

    // =============================================
    // floating lines wander every cycle
    logic float_q = 1'h0;

    always_ff @(posedge sys_clk)
    begin
        float_q <= ~float_q;
    end

    // =============================================
    // pad level: mux drive, then external driver, then pull-up
    always_comb
    begin
        for (int i = 0; i < PB_W; i++)
        begin
            pin_in_b[i] = !pad_b[i].oe_n ? pad_b[i].out : ext_en_b[i] ? ext_b[i] :
                pad_b[i].pull ? 1'h1 : float_q;
        end
        for (int j = 0; j < PD_W; j++)
        begin
            pin_in_d[j] = !pad_d[j].oe_n ? pad_d[j].out : ext_en_d[j] ? ext_d[j] :
                pad_d[j].pull ? 1'h1 : ~float_q;
        end
    end
endmodule

// ===== verification/tb_pbd_altfn_mux.sv
/*
 * self-checking bench for the port b/d override mux.
 * assumes pbd_pkg compiled first, pbd_cfg.svh on the include path, 50 mhz clock.
 */
`timescale 1ns/10ps

module tb_pbd_altfn_mux;
    import pbd_pkg::*;

    // =============================================
    // stimulus and observed signals
    logic sys_clk, rst_n, pull_up_disable, sleep_active, two_wire_mode_active, three_wire_mode_active;
    logic clock_line_hold, serial_pin_toggle_enable, serial_clk_toggle, start_cond_irq_enable;
    logic serial_data_out, serial_sda_bit, timer0_cmp_a_en, timer0_cmp_a_out, timer1_cmp_a_en;
    logic timer1_cmp_a_out, timer1_cmp_b_en, timer1_cmp_b_out, timer0_cmp_b_en, timer0_cmp_b_out;
    logic pinchg_grp0_enable, pinchg_grp2_enable, uart_rx_enable, uart_tx_enable, uart_tx_data;
    logic usart_sync_mode, usart_clk_out_en, usart_clk_out, sysclk_output_en, sysclk_output_level;
    logic ext_irq_zero_en, ext_irq_one_en, timer0_ext_clock_en, timer1_ext_clock_en, timer1_capture_en;
    logic [7:0] portb_value, portb_dir, pin_in_b, pinchg_mask_b, ext_b, ext_en_b;
    logic [6:0] portd_value, portd_dir, pin_in_d, pinchg_mask_d, ext_d, ext_en_d;
    pbd_pad_t [7:0] pad_b;
    pbd_pad_t [6:0] pad_d;
    logic [7:0] pinchg_grp0_src;
    logic [17:11] pinchg_grp2_src;
    logic serial_data_in, serial_unit_clock, uart_rx_in, ext_irq_zero, ext_irq_one, usart_sync_clock;
    logic timer0_ext_clock, timer1_ext_clock, timer1_capture_in;
    logic [14:0] pat;
    int fail_count = 0;
    int comparisons = 0;

    pbd_altfn_mux uut (.sys_clk, .rst_n, .portb_value, .portb_dir, .portd_value, .portd_dir, .pin_in_b,
        .pin_in_d, .pull_up_disable, .sleep_active, .two_wire_mode_active, .three_wire_mode_active,
        .clock_line_hold, .serial_pin_toggle_enable, .serial_clk_toggle, .start_cond_irq_enable,
        .serial_data_out, .serial_sda_bit, .timer0_cmp_a_en, .timer0_cmp_a_out, .timer1_cmp_a_en,
        .timer1_cmp_a_out, .timer1_cmp_b_en, .timer1_cmp_b_out, .timer0_cmp_b_en, .timer0_cmp_b_out,
        .pinchg_grp0_enable, .pinchg_grp2_enable, .pinchg_mask_b, .pinchg_mask_d, .uart_rx_enable,
        .uart_tx_enable, .uart_tx_data, .usart_sync_mode, .usart_clk_out_en, .usart_clk_out,
        .sysclk_output_en, .sysclk_output_level, .ext_irq_zero_en, .ext_irq_one_en, .timer0_ext_clock_en,
        .timer1_ext_clock_en, .timer1_capture_en, .pad_b, .pad_d, .pinchg_grp0_src, .pinchg_grp2_src,
        .serial_data_in, .serial_unit_clock, .uart_rx_in, .ext_irq_zero, .ext_irq_one, .usart_sync_clock,
        .timer0_ext_clock, .timer1_ext_clock, .timer1_capture_in);

    pbd_pin_model model (.sys_clk, .pad_b, .pad_d, .ext_b, .ext_en_b, .ext_d, .ext_en_d, .pin_in_b,
        .pin_in_d);

    // =============================================
    // helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // pads answer one cycle late, peripheral inputs two
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        $display("MISMATCH run length expected finish seen timeout");
        give_verdict();
    end

    // =============================================
    // main sequence; pad fields read {out, oe_n, pull, die}
    initial
    begin
        {rst_n, pull_up_disable, sleep_active, two_wire_mode_active, three_wire_mode_active} = '0;
        {clock_line_hold, serial_pin_toggle_enable, serial_clk_toggle, start_cond_irq_enable} = '0;
        {serial_data_out, serial_sda_bit, timer0_cmp_a_en, timer0_cmp_a_out, timer1_cmp_a_en} = '0;
        {timer1_cmp_a_out, timer1_cmp_b_en, timer1_cmp_b_out, timer0_cmp_b_en, timer0_cmp_b_out} = '0;
        {pinchg_grp0_enable, pinchg_grp2_enable, uart_rx_enable, uart_tx_enable, uart_tx_data} = '0;
        {usart_sync_mode, usart_clk_out_en, usart_clk_out, sysclk_output_en, sysclk_output_level} = '0;
        {ext_irq_zero_en, ext_irq_one_en, timer0_ext_clock_en, timer1_ext_clock_en, timer1_capture_en} = '0;
        {portb_value, portb_dir, pinchg_mask_b, ext_b, portd_value, portd_dir, pinchg_mask_d, ext_d} = '0;
        ext_en_b = 8'hff;
        ext_en_d = 7'h7f;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("pad_b in reset", 32'h4444_4444, pad_b);
        chk("pad_d in reset", 32'h0444_4444, pad_d);
        @(posedge sys_clk);
        rst_n <= 1'h1;
        three_wire_mode_active <= 1'h1;
        portb_dir <= 8'h60;
        serial_data_out <= 1'h1;
        settle();
        chk("pad_b6 data out high", 4'h9, pad_b[6]);
        chk("pad_b5 three-wire input pin", 4'h1, pad_b[5]);
        @(posedge sys_clk);
        serial_data_out <= 1'h0;
        portb_dir <= 8'h00;
        portb_value <= 8'h40;
        settle();
        chk("pad_b6 pull from port bit", 4'h7, pad_b[6]);
        chk("pad_b5 three-wire input pin", 4'h5, pad_b[5]);
        @(posedge sys_clk);
        pull_up_disable <= 1'h1;
        settle();
        chk("pad_b6 pull disabled", 4'h5, pad_b[6]);
        // toggle of the clock pin port value
        @(posedge sys_clk);
        pull_up_disable <= 1'h0;
        portb_value <= 8'h00;
        portb_dir <= 8'h80;
        serial_pin_toggle_enable <= 1'h1;
        serial_clk_toggle <= 1'h1;
        @(posedge sys_clk);
        serial_clk_toggle <= 1'h0;
        settle();
        chk("pad_b7 toggled", 4'h9, pad_b[7]);
        @(posedge sys_clk);
        serial_pin_toggle_enable <= 1'h0;
        three_wire_mode_active <= 1'h0;
        two_wire_mode_active <= 1'h1;
        portb_value <= 8'h80;
        portb_dir <= 8'h00;
        settle();
        chk("pad_b7 two-wire no pull", 4'hd, pad_b[7]);
        @(posedge sys_clk);
        portb_dir <= 8'ha0;
        serial_sda_bit <= 1'h1;
        settle();
        chk("pad_b7 two-wire drive low", 4'h1, pad_b[7]);
        chk("pad_b5 two-wire drive low", 4'h1, pad_b[5]);
        @(posedge sys_clk);
        portb_value <= 8'h00;
        clock_line_hold <= 1'h1;
        serial_sda_bit <= 1'h0;
        settle();
        chk("pad_b7 held", 4'h1, pad_b[7]);
        chk("pad_b5 released", 4'h5, pad_b[5]);
        @(posedge sys_clk);
        clock_line_hold <= 1'h0;
        portb_value <= 8'h20;
        settle();
        chk("pad_b7 released", 4'h5, pad_b[7]);
        chk("pad_b5 port bit drives", 4'h1, pad_b[5]);
        // lower pins, sleep, compare outputs
        @(posedge sys_clk);
        two_wire_mode_active <= 1'h0;
        portb_dir <= 8'h00;
        portb_value <= 8'h01;
        sleep_active <= 1'h1;
        pinchg_grp0_enable <= 1'h1;
        pinchg_mask_b <= 8'h01;
        {timer0_cmp_a_en, timer0_cmp_a_out, timer1_cmp_a_en, timer1_cmp_a_out} <= 4'hf;
        {timer1_cmp_b_en, timer1_cmp_b_out} <= 2'h3;
        settle();
        chk("pad_b0 masked input", 4'hf, pad_b[0]);
        chk("pad_b1 input off", 4'h4, pad_b[1]);
        chk("pad_b4..2 compare values", 12'hccc, pad_b[4:2]);
        @(posedge sys_clk);
        pinchg_grp0_enable <= 1'h0;
        {timer0_cmp_a_en, timer1_cmp_a_en, timer1_cmp_b_en} <= 3'h0;
        start_cond_irq_enable <= 1'h1;
        portb_value <= 8'h00;
        settle();
        chk("pad_b0 group off", 4'h4, pad_b[0]);
        chk("pad_b4..2 compare off", 12'h444, pad_b[4:2]);
        chk("pad_b7..5 start enable", 12'h545, pad_b[7:5]);
        // port d outputs
        @(posedge sys_clk);
        start_cond_irq_enable <= 1'h0;
        sleep_active <= 1'h0;
        {uart_tx_enable, uart_tx_data} <= 2'h3;
        portd_dir <= 7'h24;
        {sysclk_output_en, sysclk_output_level, usart_clk_out_en} <= 3'h7;
        {timer0_cmp_b_en, timer0_cmp_b_out} <= 2'h3;
        settle();
        chk("pad_d1 transmit high", 4'h9, pad_d[1]);
        chk("pad_d2 system clock", 4'h9, pad_d[2]);
        chk("pad_d5 compare b", 4'h9, pad_d[5]);
        @(posedge sys_clk);
        uart_tx_data <= 1'h0;
        sysclk_output_en <= 1'h0;
        sysclk_output_level <= 1'h0;
        usart_clk_out <= 1'h1;
        settle();
        chk("pad_d1 transmit low", 4'h1, pad_d[1]);
        chk("pad_d2 usart clock out", 4'h9, pad_d[2]);
        // inputs: walk a one over every pin
        @(posedge sys_clk);
        {uart_tx_enable, usart_clk_out_en, timer0_cmp_b_en} <= 3'h0;
        portd_dir <= 7'h01;
        portd_value <= 7'h01;
        // sleeping: only masks and enables open the inputs
        sleep_active <= 1'h1;
        pinchg_mask_b <= 8'he0;
        pinchg_mask_d <= 7'h03;
        {uart_rx_enable, ext_irq_zero_en, ext_irq_one_en} <= 3'h7;
        {timer0_ext_clock_en, timer1_ext_clock_en, timer1_capture_en} <= 3'h7;
        {pinchg_grp0_enable, pinchg_grp2_enable} <= 2'h3;
        settle();
        chk("pad_d0 receive input with pull", 4'hf, pad_d[0]);
        for (int i = 0; i < 15; i++)
        begin
            @(posedge sys_clk);
            pat = 15'h0001 << i;
            ext_b <= pat[7:0];
            ext_d <= pat[14:8];
            usart_sync_mode <= i[0];
            settle();
            chk("group 0 sources", {pat[7:5], 5'h00}, pinchg_grp0_src);
            chk("group 2 sources", pat[14:8], pinchg_grp2_src);
            chk("serial clock and data in", {pat[7], pat[5]}, {serial_unit_clock, serial_data_in});
            chk("uart receive", pat[8], uart_rx_in);
            chk("external irqs", {pat[11], pat[10]}, {ext_irq_one, ext_irq_zero});
            chk("usart sync clock", pat[10] & i[0], usart_sync_clock);
            chk("timer inputs", pat[14:12], {timer1_capture_in, timer1_ext_clock, timer0_ext_clock});
        end
        give_verdict();
    end
endmodule
